// *** card_detect_checker.sv ***
// port assertions for the card detect and global control bank
// bound to card_detect_global_ctrl; one clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "card_detect_regs.svh"
module card_detect_checker (
	input wire logic       ref_clk_i,
	input wire logic       arst_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic [1:0] card_detect_irq_enable_i,
	input wire logic [1:0] csc_cleared_i,
	input wire logic [1:0] card_irq_n_i,
	input wire logic [1:0] card_cycle_active_i,
	input wire logic [1:0] software_card_detect_event_o,
	input wire logic [1:0] card_status_change_event_o,
	input wire logic [1:0] card_irq_o,
	input wire logic       socket_a_irq_level_o,
	input wire logic       socket_b_irq_level_o,
	input wire logic       status_change_irq_level_o,
	input wire logic       flag_clear_on_write_o,
	input wire logic [1:0] card_outputs_enable_o,
	input wire logic       ring_indicate_output_n_o
);
	logic pd_reg;
	wire  gc_wr = reg_wr_i && (reg_addr_i == `GLOBAL_OFFSET_A || reg_addr_i == `GLOBAL_OFFSET_B);
	wire  sw_go = reg_wr_i && reg_addr_i == `CDGC_OFFSET_A && reg_wdata_i[5]
		&& card_detect_irq_enable_i[0];
	// shadow of the power-down bit, written through either offset
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
		if (!arst_n_i) pd_reg <= 1'b0;
		else if (gc_wr) pd_reg <= reg_wdata_i[0];
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);
	sequence gc_write_s;
		gc_wr;
	endsequence
	sequence gc_follow_s;
		{socket_b_irq_level_o, socket_a_irq_level_o, flag_clear_on_write_o,
			status_change_irq_level_o} == $past(reg_wdata_i[4:1]);
	endsequence
	chk_sw_raise: assert property (sw_go |-> software_card_detect_event_o[0])
		else $error("software detect event missing");
	chk_sw_quiet: assert property (!sw_go |-> !software_card_detect_event_o[0])
		else $error("software detect event without cause");
	chk_cd_zero: assert property (reg_rd_i && reg_addr_i == `CDGC_OFFSET_A
		|=> (reg_rdata_o & 8'h2D) == 8'h00) else $error("card detect zero bits set");
	chk_gc_zero: assert property (reg_rd_i && reg_addr_i == `GLOBAL_OFFSET_B
		|=> reg_rdata_o[7:5] == 3'h0) else $error("global reserved bits set");
	chk_gc_fields: assert property (gc_write_s |=> gc_follow_s)
		else $error("global mode outputs differ from write");
	chk_ring_hold: assert property (!ring_indicate_output_n_o && csc_cleared_i == 2'b00
		|=> !ring_indicate_output_n_o) else $error("ring released without clear");
	chk_ring_fall: assert property ($fell(ring_indicate_output_n_o)
		|-> $past(card_status_change_event_o) != 2'b00 || card_status_change_event_o != 2'b00)
		else $error("ring fell without detect change");
	chk_pd_float: assert property (pd_reg |-> card_outputs_enable_o == card_cycle_active_i)
		else $error("power-down enables wrong");
	chk_pd_off: assert property (!pd_reg |-> card_outputs_enable_o == 2'b11)
		else $error("card outputs not driven");
	chk_irq_pass: assert property (!card_irq_n_i[0] [*4] |-> card_irq_o[0])
		else $error("card irq not passed");
endmodule
bind card_detect_global_ctrl card_detect_checker i_card_detect_checker (
	.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .card_detect_irq_enable_i(card_detect_irq_enable_i),
	.csc_cleared_i(csc_cleared_i), .card_irq_n_i(card_irq_n_i),
	.card_cycle_active_i(card_cycle_active_i),
	.software_card_detect_event_o(software_card_detect_event_o),
	.card_status_change_event_o(card_status_change_event_o), .card_irq_o(card_irq_o),
	.socket_a_irq_level_o(socket_a_irq_level_o), .socket_b_irq_level_o(socket_b_irq_level_o),
	.status_change_irq_level_o(status_change_irq_level_o),
	.flag_clear_on_write_o(flag_clear_on_write_o),
	.card_outputs_enable_o(card_outputs_enable_o),
	.ring_indicate_output_n_o(ring_indicate_output_n_o));
`default_nettype wire

// *** card_detect_global_ctrl.sv ***
// card detect and global control register bank for a dual-socket card controller
// byte register port on ref_clk_i; card pins are asynchronous and synchronised here
//
// Contract
// RULE1 - bit 7 reads live level of second voltage-sense pin
// RULE2 - bit 6 reads live level of first voltage-sense pin
// RULE3 - writing 1 to bit 5 with detect irq enabled raises status-change event
// RULE4 - with detect irq disabled, writing 1 to bit 5 does nothing
// RULE5 - software card-detect bit always reads 0
// RULE6 - wake enable set: card-detect change drives ring-indicate output low
// RULE7 - ring-indicate stays low until status-change flag is cleared
// RULE8 - bit 1 set: card removal resets that socket's registers
// RULE9 - card detect register bits 3, 2 and 0 read 0
// RULE10 - global control bits 7 to 5 read 0
// RULE11 - global control is one shared instance for both sockets
// RULE12 - global bit 4 selects edge or level host irq for socket B
// RULE13 - global bit 3 selects edge or level host irq for socket A
// RULE14 - global bit 2: clear flags on read or on write of 1
// RULE15 - global bit 1 selects edge or level status-change host irq
// RULE16 - power-down: card outputs float except during active card cycle
// RULE17 - power-down still accepts card interrupts; only access wakes interface
`timescale 1ns/1ps
`default_nettype none
`include "card_detect_regs.svh"
module card_detect_global_ctrl (
	// clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       arst_n_i,
	// register port
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output var  logic [7:0] reg_rdata_o,
	// status-change side: detect irq enables and flag clears per socket
	input  wire logic [1:0] card_detect_irq_enable_i,
	input  wire logic [1:0] csc_cleared_i,
	// card pins, asynchronous, index 0 socket A, 1 socket B
	input  wire logic [1:0] voltage_sense_one_n_i,
	input  wire logic [1:0] voltage_sense_two_n_i,
	input  wire logic [1:0] card_detect_first_n_i,
	input  wire logic [1:0] card_detect_second_n_i,
	input  wire logic [1:0] card_irq_n_i,
	// card cycle activity from the access engine
	input  wire logic [1:0] card_cycle_active_i,
	// outputs to the status-change and host irq logic
	output logic [1:0]      software_card_detect_event_o,
	output logic [1:0]      card_status_change_event_o,
	output logic [1:0]      socket_regs_reset_o,
	output logic [1:0]      card_irq_o,
	output logic            socket_a_irq_level_o,
	output logic            socket_b_irq_level_o,
	output logic            status_change_irq_level_o,
	output logic            flag_clear_on_write_o,
	output logic [1:0]      card_outputs_enable_o,
	output logic            ring_indicate_output_n_o
);
	logic [7:0] global_reg;
	logic [7:0] global_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic [1:0] sync1_vs1_reg, sync2_vs1_reg;
	logic [1:0] sync1_vs2_reg, sync2_vs2_reg;
	logic [1:0] sync1_cd1_reg, sync2_cd1_reg;
	logic [1:0] sync1_cd2_reg, sync2_cd2_reg;
	logic [1:0] sync1_irq_reg, sync2_irq_reg;
	logic [1:0] prev_cd1_reg, prev_cd2_reg;
	logic [1:0] present_reg;
	logic [1:0] detect_change;
	logic [1:0] removal;
	logic [1:0] ring_low;
	logic [1:0] cdgc_hit;
	logic [1:0] cdgc_wr;
	logic [7:0] cdgc_rdata [2];
	logic       global_hit;
	logic       power_down;
	card_detect_pkg::irq_style_t        style_a;
	card_detect_pkg::irq_style_t        style_b;
	card_detect_pkg::irq_style_t        style_csc;
	card_detect_pkg::flag_clear_style_t clear_style;

	// address decode; both socket offsets land on the single global register
	assign cdgc_hit[0] = reg_addr_i == `CDGC_OFFSET_A;
	assign cdgc_hit[1] = reg_addr_i == `CDGC_OFFSET_B;
	assign global_hit  = (reg_addr_i == `GLOBAL_OFFSET_A) || // [RULE11]
	                     (reg_addr_i == `GLOBAL_OFFSET_B);
	assign cdgc_wr     = cdgc_hit & {2{reg_wr_i}};

	// reserved top bits never stored
	assign global_next = (reg_wr_i && global_hit) ? (reg_wdata_i & `GC_WRITE_MASK) // [RULE10]
	                                              : global_reg;

	assign style_b     = card_detect_pkg::irq_style_t'(global_reg[`GC_IRQ_B_BIT]);
	assign style_a     = card_detect_pkg::irq_style_t'(global_reg[`GC_IRQ_A_BIT]);
	assign style_csc   = card_detect_pkg::irq_style_t'(global_reg[`GC_CSC_STYLE_BIT]);
	assign clear_style = card_detect_pkg::flag_clear_style_t'(global_reg[`GC_FLAG_CLEAR_BIT]);
	assign power_down  = global_reg[`GC_POWER_DOWN_BIT];

	assign socket_b_irq_level_o      = style_b == card_detect_pkg::IRQ_LEVEL; // [RULE12]
	assign socket_a_irq_level_o      = style_a == card_detect_pkg::IRQ_LEVEL; // [RULE13]
	assign status_change_irq_level_o = style_csc == card_detect_pkg::IRQ_LEVEL; // [RULE15]
	// status-change register lives elsewhere; it takes its clear style from here
	assign flag_clear_on_write_o     = clear_style == card_detect_pkg::CLEAR_ON_WRITE_ONE; // [RULE14]

	// power-down floats card outputs between active cycles
	assign card_outputs_enable_o = power_down ? card_cycle_active_i : 2'b11; // [RULE16]
	// card interrupts pass regardless of power-down
	assign card_irq_o = ~sync2_irq_reg; // [RULE17]

	// either detect pin moving counts as a change; both high means no card
	assign detect_change = (sync2_cd1_reg ^ prev_cd1_reg) | (sync2_cd2_reg ^ prev_cd2_reg);
	assign removal       = present_reg & (sync2_cd1_reg | sync2_cd2_reg);
	assign card_status_change_event_o = detect_change;

	// any socket waking pulls the shared ring line low
	assign ring_indicate_output_n_o = ~(|ring_low); // [RULE6] [RULE7]

	assign rdata_next = !reg_rd_i   ? rdata_reg :
	                    cdgc_hit[0] ? cdgc_rdata[0] :
	                    cdgc_hit[1] ? cdgc_rdata[1] :
	                    global_hit  ? global_reg : 8'h00;
	assign reg_rdata_o = rdata_reg;

	genvar s;
	generate
		for (s = 0; s < 2; s++) begin : g_socket
			socket_ctrl_if ctl ();

			assign ctl.wdata         = reg_wdata_i;
			assign ctl.wr_strobe     = cdgc_wr[s];
			assign ctl.csc_cleared   = csc_cleared_i[s];
			assign ctl.detect_change = detect_change[s];
			assign ctl.removal       = removal[s];
			assign ctl.irq_enable    = card_detect_irq_enable_i[s];
			assign cdgc_rdata[s]     = ctl.rdata;
			assign software_card_detect_event_o[s] = ctl.sw_event; // [RULE3]
			assign ring_low[s]       = ctl.ring_low;
			assign socket_regs_reset_o[s] = ctl.reset_regs; // [RULE8]

			socket_detect_slice u_slice (
				.ref_clk_i         (ref_clk_i),
				.arst_n_i          (arst_n_i),
				// status bits report the pin level itself, high pin reads 1
				.sense_one_level_i (sync2_vs1_reg[s]), // [RULE2]
				.sense_two_level_i (sync2_vs2_reg[s]), // [RULE1]
				.ctl               (ctl)
			);
		end
	endgenerate

	// two-flop synchronisers; only the second stage is read
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sync1_vs1_reg <= 2'h3;
			sync2_vs1_reg <= 2'h3;
			sync1_vs2_reg <= 2'h3;
			sync2_vs2_reg <= 2'h3;
			sync1_cd1_reg <= 2'h3;
			sync2_cd1_reg <= 2'h3;
			sync1_cd2_reg <= 2'h3;
			sync2_cd2_reg <= 2'h3;
			sync1_irq_reg <= 2'h3;
			sync2_irq_reg <= 2'h3;
		end else begin
			sync1_vs1_reg <= voltage_sense_one_n_i;
			sync2_vs1_reg <= sync1_vs1_reg;
			sync1_vs2_reg <= voltage_sense_two_n_i;
			sync2_vs2_reg <= sync1_vs2_reg;
			sync1_cd1_reg <= card_detect_first_n_i;
			sync2_cd1_reg <= sync1_cd1_reg;
			sync1_cd2_reg <= card_detect_second_n_i;
			sync2_cd2_reg <= sync1_cd2_reg;
			sync1_irq_reg <= card_irq_n_i;
			sync2_irq_reg <= sync1_irq_reg;
		end
	end

	// reset assumes empty sockets so a card present at start shows as a change
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prev_cd1_reg <= 2'h3;
			prev_cd2_reg <= 2'h3;
			present_reg  <= 2'h0;
			global_reg   <= `GC_RESET;
			rdata_reg    <= 8'h00;
		end else begin
			prev_cd1_reg <= sync2_cd1_reg;
			prev_cd2_reg <= sync2_cd2_reg;
			present_reg  <= ~sync2_cd1_reg & ~sync2_cd2_reg;
			global_reg   <= global_next;
			rdata_reg    <= rdata_next;
		end
	end
endmodule
`default_nettype wire

// *** card_detect_global_ctrl_test.sv ***
// self-checking bench for card_detect_global_ctrl with a card model
// inputs driven on the falling edge; reads scored from a queue
`timescale 1ns/1ps
`default_nettype none
module card_detect_global_ctrl_test;
	logic       ref_clk_i = 1'b0;
	logic       arst_n_i = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic       wr = 1'b0, rd = 1'b0, rd_d = 1'b0, ring, rst_seen = 1'b0;
	logic       chg_seen = 1'b0;
	logic [1:0] csc_ev;
	logic       lv_a, lv_b, lv_c, lv_f;
	logic [1:0] irq_en = 2'b00, cleared = 2'b00, active = 2'b00, present = 2'b11;
	logic [1:0] s1 = 2'b00, s2 = 2'b00, cirq = 2'b00, sw_ev, rst_ev, cirq_o, oe;
	logic [1:0] vs1_n, vs2_n, cd_n, irq_n;
	logic [7:0] q[$];
	int         n_errors = 0;
	int         checks = 0;
	card_detect_global_ctrl i_card_detect_global_ctrl (.ref_clk_i(ref_clk_i),
		.arst_n_i(arst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_rdata_o(rdata), .card_detect_irq_enable_i(irq_en),
		.csc_cleared_i(cleared), .voltage_sense_one_n_i(vs1_n), .voltage_sense_two_n_i(vs2_n),
		.card_detect_first_n_i(cd_n), .card_detect_second_n_i(cd_n), .card_irq_n_i(irq_n),
		.card_cycle_active_i(active), .software_card_detect_event_o(sw_ev),
		.card_status_change_event_o(csc_ev), .socket_regs_reset_o(rst_ev), .card_irq_o(cirq_o),
		.socket_a_irq_level_o(lv_a), .socket_b_irq_level_o(lv_b),
		.status_change_irq_level_o(lv_c), .flag_clear_on_write_o(lv_f),
		.card_outputs_enable_o(oe), .ring_indicate_output_n_o(ring));
	card_model i_card_model (.present_i(present), .sense_one_n_i(s1), .sense_two_n_i(s2),
		.irq_i(cirq), .voltage_sense_one_n_o(vs1_n), .voltage_sense_two_n_o(vs2_n),
		.card_detect_n_o(cd_n), .card_irq_n_o(irq_n));
	initial forever #25 ref_clk_i = ~ref_clk_i;
	task automatic chk(input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	task automatic stop_test;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic [1:0] ev);
		@(negedge ref_clk_i);
		addr = a;
		wdata = d;
		wr = 1'b1;
		#1 chk({6'h00, ev}, {6'h00, sw_ev});
		@(negedge ref_clk_i);
		wr = 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
		@(negedge ref_clk_i);
		addr = a;
		rd = 1'b1;
		q.push_back(exp);
		@(negedge ref_clk_i);
		rd = 1'b0;
	endtask
	always @(posedge ref_clk_i) rd_d <= rd;
	always @(posedge ref_clk_i) if (rst_ev[0]) rst_seen <= 1'b1;
	always @(posedge ref_clk_i) if (csc_ev[0]) chg_seen <= 1'b1;
	// read data is registered: score it on the falling edge after the read edge
	always @(negedge ref_clk_i) if (rd_d) chk(q.pop_front(), rdata);
	initial begin
		#(2000 * 50);
		n_errors++;
		stop_test();
	end
	initial begin
		logic [7:0] v;
		void'($urandom(32'h40dd));
		s1 = 2'($urandom);
		s2 = 2'($urandom);
		repeat (20) @(negedge ref_clk_i);
		arst_n_i = 1'b1;
		repeat (4) @(negedge ref_clk_i);
		rd_reg(8'h16, {s2[0], s1[0], 6'h00});
		rd_reg(8'h56, {s2[1], s1[1], 6'h00});
		rd_reg(8'h1E, 8'h00);
		rd_reg(8'h20, 8'h00);
		for (int i = 0; i < 6; i++) begin
			v = (i == 5) ? 8'hFF : 8'($urandom);
			wr_reg(i[0] ? 8'h5E : 8'h1E, v, 2'b00);
			rd_reg(i[0] ? 8'h1E : 8'h5E, v & 8'h1F);
			chk({4'h0, v[4:1]}, {4'h0, lv_b, lv_a, lv_f, lv_c});
		end
		wr_reg(8'h1E, 8'h00, 2'b00);
		irq_en = 2'b01;
		wr_reg(8'h16, 8'h20, 2'b01);
		wr_reg(8'h56, 8'h20, 2'b00);
		irq_en = 2'b10;
		wr_reg(8'h56, 8'h20, 2'b10);
		wr_reg(8'h16, 8'hFF, 2'b00);
		rd_reg(8'h16, {s2[0], s1[0], 6'h12});
		for (int m = 0; m < 3; m++) begin
			v = (m == 0) ? 8'h12 : (m == 1) ? 8'h10 : 8'h00;
			wr_reg(8'h16, v, 2'b00);
			rst_seen = 1'b0;
			chg_seen = 1'b0;
			present = 2'b10;
			repeat (10) @(negedge ref_clk_i);
			chk({7'h00, ~v[4]}, {7'h00, ring});
			chk({7'h00, v[1]}, {7'h00, rst_seen});
			chk(8'h01, {7'h00, chg_seen});
			present = 2'b11;
			repeat (6) @(negedge ref_clk_i);
			cleared = 2'b01;
			@(negedge ref_clk_i);
			cleared = 2'b00;
			repeat (3) @(negedge ref_clk_i);
			chk(8'h01, {7'h00, ring});
		end
		wr_reg(8'h1E, 8'h01, 2'b00);
		for (int i = 0; i < 4; i++) begin
			active = 2'($urandom);
			#1 chk({6'h00, active}, {6'h00, oe});
			@(negedge ref_clk_i);
		end
		cirq = 2'b11;
		repeat (5) @(negedge ref_clk_i);
		chk(8'h03, {6'h00, cirq_o});
		cirq = 2'b00;
		wr_reg(8'h1E, 8'h00, 2'b00);
		chk(8'h03, {6'h00, oe});
		stop_test();
	end
endmodule
`default_nettype wire

// *** card_detect_pkg.sv ***
// types shared by the card detect bank files
// constants live in card_detect_regs.svh
package card_detect_pkg;
	typedef enum logic {IRQ_EDGE, IRQ_LEVEL} irq_style_t;
	typedef enum logic {CLEAR_ON_READ, CLEAR_ON_WRITE_ONE} flag_clear_style_t;
endpackage

// *** card_detect_regs.svh ***
// register offsets, field positions, reset values for the card detect / global control bank
// included by the checker and design files; byte-wide register port
`ifndef CARD_DETECT_REGS_SVH
`define CARD_DETECT_REGS_SVH
`define CDGC_OFFSET_A      8'h16
`define CDGC_OFFSET_B      8'h56
`define GLOBAL_OFFSET_A    8'h1E
`define GLOBAL_OFFSET_B    8'h5E
`define CDGC_SENSE_TWO_BIT 7
`define CDGC_SENSE_ONE_BIT 6
`define CDGC_SW_EVENT_BIT  5
`define CDGC_WAKE_BIT      4
`define CDGC_REMOVAL_BIT   1
`define GC_IRQ_B_BIT       4
`define GC_IRQ_A_BIT       3
`define GC_FLAG_CLEAR_BIT  2
`define GC_CSC_STYLE_BIT   1
`define GC_POWER_DOWN_BIT  0
`define GC_WRITE_MASK      8'h1F
`define CDGC_WRITE_MASK    8'h12
`define GC_RESET           8'h00
`define CDGC_RESET         8'h00
`endif

// *** card_model.sv ***
// behavioural card in each socket: detect, sense and irq pins
// an empty socket leaves every pin to its pull-up
`timescale 1ns/1ps
`default_nettype none
module card_model (
	input  wire logic [1:0] present_i,
	input  wire logic [1:0] sense_one_n_i,
	input  wire logic [1:0] sense_two_n_i,
	input  wire logic [1:0] irq_i,
	output logic [1:0]      voltage_sense_one_n_o,
	output logic [1:0]      voltage_sense_two_n_o,
	output logic [1:0]      card_detect_n_o,
	output logic [1:0]      card_irq_n_o
);
	assign card_detect_n_o = ~present_i;
	assign voltage_sense_one_n_o = sense_one_n_i | ~present_i;
	assign voltage_sense_two_n_o = sense_two_n_i | ~present_i;
	assign card_irq_n_o = ~(irq_i & present_i);
endmodule
`default_nettype wire

// *** socket_ctrl_if.sv ***
// per-socket control bundle between the bank top and each socket slice
// single clock domain
`timescale 1ns/1ps
`default_nettype none
interface socket_ctrl_if;
	logic [7:0] wdata;
	logic       wr_strobe;
	logic       csc_cleared;
	logic       detect_change;
	logic       removal;
	logic       irq_enable;
	logic [7:0] rdata;
	logic       sw_event;
	logic       ring_low;
	logic       reset_regs;
	modport top   (output wdata, wr_strobe, csc_cleared, detect_change, removal, irq_enable,
	               input rdata, sw_event, ring_low, reset_regs);
	modport slice (input wdata, wr_strobe, csc_cleared, detect_change, removal, irq_enable,
	               output rdata, sw_event, ring_low, reset_regs);
endinterface
`default_nettype wire

// *** socket_detect_slice.sv ***
// one socket's card detect and general control register plus wake latch
// synchronised sense levels and detect events supplied by the top
`timescale 1ns/1ps
`default_nettype none
`include "card_detect_regs.svh"
module socket_detect_slice (
	// clock and reset
	input  wire logic          ref_clk_i,
	input  wire logic          arst_n_i,
	// synchronised sense pins
	input  wire logic          sense_one_level_i,
	input  wire logic          sense_two_level_i,
	// control bundle
	socket_ctrl_if.slice       ctl
);
	logic [7:0] ctrl_reg;
	logic [7:0] ctrl_next;
	logic       ring_low_reg;
	logic       ring_low_next;
	logic       wake_en;
	logic       sw_write;

	assign wake_en  = ctrl_reg[`CDGC_WAKE_BIT];
	assign sw_write = ctl.wr_strobe && ctl.wdata[`CDGC_SW_EVENT_BIT];
	// event only when detect irq enabled, otherwise write of 1 is dropped
	assign ctl.sw_event   = sw_write && ctl.irq_enable; // [RULE3] [RULE4]
	assign ctl.reset_regs = ctl.removal && ctrl_reg[`CDGC_REMOVAL_BIT]; // [RULE8]
	assign ctrl_next = ctl.reset_regs ? `CDGC_RESET :
	                   ctl.wr_strobe ? (ctl.wdata & `CDGC_WRITE_MASK) : ctrl_reg;
	// a fresh change wins over a same-cycle clear so no wake is lost
	assign ring_low_next = (wake_en && ctl.detect_change) ? 1'b1 : // [RULE6]
	                       ctl.csc_cleared ? 1'b0 : ring_low_reg; // [RULE7]
	assign ctl.ring_low = ring_low_reg;
	// sense bits live, sw event bit and reserved bits read zero
	assign ctl.rdata = {sense_two_level_i, sense_one_level_i, 1'b0, // [RULE1] [RULE2] [RULE5]
	                    ctrl_reg[`CDGC_WAKE_BIT], 2'b00, ctrl_reg[`CDGC_REMOVAL_BIT], 1'b0}; // [RULE9]

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_reg     <= `CDGC_RESET;
			ring_low_reg <= 1'b0;
		end else begin
			ctrl_reg     <= ctrl_next;
			ring_low_reg <= ring_low_next;
		end
	end
endmodule
`default_nettype wire
